// [rtl/tcx_pkg.sv]
/*
  Shared constants and types of the compensated oscillator control logic.
  Assumes one 100 MHz clock for all state.
*/
`default_nettype none
package tcx_pkg;
  localparam logic [7:0] REG_DIVIDER = 8'h5d;
  localparam logic [7:0] REG_CONTROL = 8'h60;
  localparam logic [7:0] REG_TEMP_HI = 8'h64;
  localparam logic [7:0] REG_TEMP_LO = 8'h65;
  localparam logic [7:0] REG_FREQ_OFFSET = 8'h66;
  localparam int CTL_HALF_DUTY = 0;
  localparam int CTL_TEST = 1;
  localparam int CTL_BASE_OE = 2;
  localparam int CTL_DIV_OE = 3;
  localparam int CTL_W = 4;
  localparam logic [3:0] CTL_RESET = 4'hc;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [7:0] OFS_RESET = 8'h00;
  localparam logic [3:0] CTL_PAD = 4'h0;
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h22;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int TEMP_W = 10;
  localparam int TEMP_FRAC_W = 2;
  localparam logic [5:0] TEMP_LO_PAD = 6'h00;
  localparam int LOAD_W = 10;
  localparam int OFS_W = 8;
  localparam logic [TEMP_W-1:0] TEMP_RESET = 10'h000;
  localparam logic [LOAD_W-1:0] LOAD_RESET = 10'h000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_CMD, ST_WDATA, ST_RDATA, ST_MACK, ST_SKIP
  } tcx_bus_st_t;
  typedef enum logic [1:0] {AF_CMD, AF_WDATA, AF_RDATA} tcx_after_t;
endpackage
`default_nettype wire

// [rtl/tcx_clk_div.sv]
/*
  Output clock divider and glitch-free output gating.
  Assumes mclk_in is the base crystal clock; control inputs are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module tcx_clk_div
  import tcx_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [DIV_W-1:0] divider_value_in,
  input wire logic half_duty_select_in,
  input wire logic base_output_enable_in,
  input wire logic divided_output_enable_in,
  output logic base_clock_output_out,
  output logic divided_clock_output_out
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] last_val;
    logic last_dc;
    logic div_q;
  } tcx_div_t;
  tcx_div_t s_r, s_nxt;
  logic base_gate_r, byp_gate_r, byp_sel_r, bypass, restart;
  logic [DIV_W-1:0] half;
  assign bypass = (divider_value_in == '0) && !half_duty_select_in;
  assign half = DIV_W'(({1'b0, divider_value_in} + 1'b1) >> 1);
  assign restart = (divider_value_in != s_r.last_val) ||
                   (half_duty_select_in != s_r.last_dc);
  always_comb begin
    s_nxt = s_r;
    if (restart) begin
      s_nxt.cnt = '0;
      s_nxt.div_q = 1'b0;
      s_nxt.last_val = divider_value_in;
      s_nxt.last_dc = half_duty_select_in;
    end else if (s_r.cnt == divider_value_in) begin
      s_nxt.cnt = '0;
      if (half_duty_select_in) begin
        s_nxt.div_q = s_r.div_q ? 1'b0 : divided_output_enable_in;
      end else begin
        s_nxt.div_q = divided_output_enable_in && !bypass;
      end
    end else begin
      s_nxt.cnt = DIV_W'(s_r.cnt + 1'b1);
      if (!half_duty_select_in && (s_nxt.cnt == half)) begin
        s_nxt.div_q = 1'b0;
      end
    end
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '0;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end
  // Gates change only while the clock is low
  always_ff @(negedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      base_gate_r <= 1'b0;
      byp_gate_r <= 1'b0;
      byp_sel_r <= 1'b0;
    end else if (ce_in) begin
      base_gate_r <= base_output_enable_in;
      byp_gate_r <= divided_output_enable_in && bypass;
      byp_sel_r <= bypass;
    end
  end
  assign base_clock_output_out = mclk_in & base_gate_r;
  assign divided_clock_output_out = byp_sel_r ? (mclk_in & byp_gate_r) :
                                    s_r.div_q;
  property p_restart;
    @(posedge mclk_in) disable iff (!resetn_in)
    (ce_in && restart) |=> (s_r.cnt == '0) && !s_r.div_q;
  endproperty
  a_restart: assert property (p_restart) else $error("divider not restarted");
  property p_half_toggle;
    @(posedge mclk_in) disable iff (!resetn_in)
    (ce_in && !restart && half_duty_select_in && s_r.div_q &&
     s_r.cnt == divider_value_in) |=> !s_r.div_q;
  endproperty
  a_half_toggle: assert property (p_half_toggle) else $error("no toggle");
endmodule
`default_nettype wire

// [rtl/tcx_temp_track.sv]
/*
  Background temperature conversion sequencing and tuning application.
  Assumes the sensor answers each start with a one-cycle done pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module tcx_temp_track
  import tcx_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic temp_done_in,
  input wire logic [TEMP_W-1:0] temp_result_in,
  input wire logic [OFS_W-1:0] frequency_offset_in,
  input wire logic [LOAD_W-1:0] factory_comp_in,
  output logic conv_start_out,
  output logic [TEMP_W-1:0] temp_word_out,
  output logic [LOAD_W-1:0] crystal_load_out
);
  typedef struct packed {
    logic booted;
    logic start;
    logic [TEMP_W-1:0] result;
    logic [LOAD_W-1:0] load;
  } tcx_temp_t;
  tcx_temp_t s_r, s_nxt;
  logic [LOAD_W-1:0] ofs_ext;
  assign ofs_ext = LOAD_W'($signed(frequency_offset_in));
  always_comb begin
    s_nxt = s_r;
    s_nxt.booted = 1'b1;
    s_nxt.start = !s_r.booted || temp_done_in;
    if (temp_done_in) begin
      s_nxt.result = temp_result_in;
      s_nxt.load = LOAD_W'(factory_comp_in + ofs_ext);
    end
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '{booted: 1'b0, start: 1'b0, result: TEMP_RESET,
               load: LOAD_RESET};
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end
  assign conv_start_out = s_r.start;
  assign temp_word_out = s_r.result;
  assign crystal_load_out = s_r.load;
  property p_hold;
    @(posedge mclk_in) disable iff (!resetn_in)
    !temp_done_in |=> $stable(s_r.result) && $stable(s_r.load);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed idle");
  property p_apply;
    @(posedge mclk_in) disable iff (!resetn_in)
    (ce_in && temp_done_in) |=> conv_start_out &&
      (crystal_load_out == LOAD_W'($past(factory_comp_in) +
       LOAD_W'($signed($past(frequency_offset_in)))));
  endproperty
  a_apply: assert property (p_apply) else $error("tuning not applied");
endmodule
`default_nettype wire

// [rtl/tcx_ctrl_top.sv]
/*
  Top of the compensated oscillator control: 2-wire slave, register file,
  output divider and temperature tracking.
  Assumes open-drain pins resolved outside; sensor and comp logic on mclk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module tcx_ctrl_top
  import tcx_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic address_select_pin_in,
  input wire logic temp_done_in,
  input wire logic [TEMP_W-1:0] temp_result_in,
  input wire logic [LOAD_W-1:0] factory_comp_in,
  output logic conv_start_out,
  output logic [LOAD_W-1:0] crystal_load_out,
  output logic base_clock_output_out,
  output logic divided_clock_output_out
);
  typedef struct packed {
    tcx_bus_st_t st;
    tcx_after_t after;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic a0_m;
    logic a0_s;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic ptr_ok;
    logic [7:0] ptr;
    logic second;
    logic [7:0] lo_hold;
    logic sda_oe_n;
    logic [7:0] divider_value;
    logic [CTL_W-1:0] ctrl;
    logic [7:0] freq_ofs;
  } tcx_top_t;

  tcx_top_t s_r, s_nxt;
  logic rise, fall, start_c, stop_c, byte_end, addr_hit;
  logic [TEMP_W-1:0] temp_word;

  function automatic logic is_mapped(input logic [7:0] code);
    is_mapped = (code == REG_DIVIDER) || (code == REG_CONTROL) ||
                (code == REG_TEMP_HI) || (code == REG_TEMP_LO) ||
                (code == REG_FREQ_OFFSET);
  endfunction

  function automatic logic is_writable(input logic [7:0] code);
    is_writable = (code == REG_DIVIDER) || (code == REG_CONTROL) ||
                  (code == REG_FREQ_OFFSET);
  endfunction

  function automatic logic [7:0] temp_lo(input logic [TEMP_W-1:0] t);
    temp_lo = {t[TEMP_FRAC_W-1:0], TEMP_LO_PAD};
  endfunction

  // Bus conditions seen on the synchronised pins
  assign rise = s_r.scl_s && !s_r.scl_d;
  assign fall = !s_r.scl_s && s_r.scl_d;
  assign start_c = s_r.scl_s && s_r.scl_d && s_r.sda_d && !s_r.sda_s;
  assign stop_c = s_r.scl_s && s_r.scl_d && !s_r.sda_d && s_r.sda_s;
  assign byte_end = fall && (s_r.bitcnt == BITS_PER_BYTE);
  assign addr_hit = (s_r.shreg[7:1] == {SLAVE_ADDR_HI, s_r.a0_s});

  always_comb begin
    logic [7:0] rd;
    rd = UNMAPPED_READ;
    s_nxt = s_r;
    s_nxt.scl_m = scl_in;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_d = s_r.scl_s;
    s_nxt.sda_m = sda_in;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_d = s_r.sda_s;
    s_nxt.a0_m = address_select_pin_in;
    s_nxt.a0_s = s_r.a0_m;
    // Read source for the current pointer
    case (s_r.ptr)
      REG_DIVIDER: rd = s_r.divider_value;
      REG_CONTROL: rd = {CTL_PAD, s_r.ctrl};
      REG_TEMP_HI: rd = temp_word[TEMP_W-1:TEMP_FRAC_W];
      REG_TEMP_LO: rd = temp_lo(temp_word);
      REG_FREQ_OFFSET: rd = s_r.freq_ofs;
      default: rd = UNMAPPED_READ;
    endcase
    if (start_c) begin
      s_nxt.st = ST_ADDR;
      s_nxt.bitcnt = BIT_ZERO;
      s_nxt.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      s_nxt.st = ST_IDLE;
      s_nxt.sda_oe_n = 1'b1;
    end else begin
      case (s_r.st)
        ST_IDLE: begin
          s_nxt.sda_oe_n = 1'b1;
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (rise) begin
            s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_s};
            s_nxt.bitcnt = 4'(s_r.bitcnt + BIT_ONE);
          end else if (byte_end) begin
            s_nxt.bitcnt = BIT_ZERO;
            s_nxt.st = ST_SKIP;
            case (s_r.st)
              ST_ADDR: begin
                if (addr_hit) begin
                  s_nxt.st = ST_ACK;
                  s_nxt.sda_oe_n = 1'b0;
                  s_nxt.after = s_r.shreg[0] ? AF_RDATA : AF_CMD;
                end
              end
              ST_CMD: begin
                s_nxt.ptr = s_r.shreg;
                s_nxt.ptr_ok = is_mapped(s_r.shreg);
                if (is_mapped(s_r.shreg)) begin
                  s_nxt.st = ST_ACK;
                  s_nxt.sda_oe_n = 1'b0;
                  s_nxt.after = AF_WDATA;
                end
              end
              default: begin
                s_nxt.ptr_ok = 1'b0;
                if (s_r.ptr_ok && is_writable(s_r.ptr)) begin
                  s_nxt.st = ST_ACK;
                  s_nxt.sda_oe_n = 1'b0;
                  s_nxt.after = AF_CMD;
                  case (s_r.ptr)
                    REG_DIVIDER: s_nxt.divider_value = s_r.shreg;
                    REG_CONTROL: s_nxt.ctrl = s_r.shreg[CTL_W-1:0];
                    default: s_nxt.freq_ofs = s_r.shreg;
                  endcase
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (fall) begin
            s_nxt.sda_oe_n = 1'b1;
            s_nxt.bitcnt = BIT_ZERO;
            case (s_r.after)
              AF_CMD: begin
                s_nxt.st = (s_r.ptr_ok || s_r.st != ST_ACK) ?
                           ST_CMD : ST_CMD;
                if (s_r.shreg[0] == 1'b0 && s_r.ptr_ok) begin
                  s_nxt.st = ST_SKIP;
                end
              end
              AF_WDATA: begin
                s_nxt.st = ST_WDATA;
              end
              default: begin
                s_nxt.second = 1'b0;
                if (s_r.ptr_ok) begin
                  s_nxt.st = ST_RDATA;
                  s_nxt.shreg = rd;
                  s_nxt.sda_oe_n = rd[7];
                  s_nxt.lo_hold = temp_lo(temp_word);
                end else begin
                  s_nxt.st = ST_SKIP;
                end
              end
            endcase
          end
        end
        ST_RDATA: begin
          if (rise) begin
            s_nxt.bitcnt = 4'(s_r.bitcnt + BIT_ONE);
          end else if (byte_end) begin
            s_nxt.sda_oe_n = 1'b1;
            s_nxt.bitcnt = BIT_ZERO;
            s_nxt.st = ST_MACK;
          end else if (fall) begin
            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
            s_nxt.sda_oe_n = s_r.shreg[6];
          end
        end
        ST_MACK: begin
          if (rise) begin
            s_nxt.bitcnt = BIT_ONE;
            if (s_r.sda_s) begin
              s_nxt.st = ST_SKIP;
              s_nxt.ptr_ok = 1'b0;
            end
          end else if (fall && s_r.bitcnt == BIT_ONE) begin
            s_nxt.bitcnt = BIT_ZERO;
            if (s_r.ptr == REG_TEMP_HI && !s_r.second) begin
              s_nxt.st = ST_RDATA;
              s_nxt.second = 1'b1;
              s_nxt.shreg = s_r.lo_hold;
              s_nxt.sda_oe_n = s_r.lo_hold[7];
            end else begin
              s_nxt.st = ST_SKIP;
              s_nxt.ptr_ok = 1'b0;
            end
          end
        end
        ST_SKIP: begin
          s_nxt.sda_oe_n = 1'b1;
        end
        default: begin
          s_nxt.st = ST_IDLE;
          s_nxt.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '{st: ST_IDLE, after: AF_CMD, scl_m: 1'b1, scl_s: 1'b1,
               scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
               a0_m: 1'b0, a0_s: 1'b0, bitcnt: BIT_ZERO, shreg: 8'h00,
               ptr_ok: 1'b0, ptr: 8'h00, second: 1'b0, lo_hold: 8'h00,
               sda_oe_n: 1'b1, divider_value: DIV_RESET,
               ctrl: CTL_RESET, freq_ofs: OFS_RESET};
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n_out = s_r.sda_oe_n;

  tcx_clk_div #(
    .DIV_W(8)
  ) u_div (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .divider_value_in(s_r.divider_value),
    .half_duty_select_in(s_r.ctrl[CTL_HALF_DUTY]),
    .base_output_enable_in(s_r.ctrl[CTL_BASE_OE]),
    .divided_output_enable_in(s_r.ctrl[CTL_DIV_OE]),
    .base_clock_output_out(base_clock_output_out),
    .divided_clock_output_out(divided_clock_output_out)
  );

  tcx_temp_track u_temp (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .temp_done_in(temp_done_in),
    .temp_result_in(temp_result_in),
    .frequency_offset_in(s_r.freq_ofs),
    .factory_comp_in(factory_comp_in),
    .conv_start_out(conv_start_out),
    .temp_word_out(temp_word),
    .crystal_load_out(crystal_load_out)
  );

  sequence s_byte_done(tcx_bus_st_t st);
    ce_in && !start_c && !stop_c && byte_end && s_r.st == st;
  endsequence

  property p_addr_miss;
    @(posedge mclk_in) disable iff (!resetn_in)
    s_byte_done(ST_ADDR) and !addr_hit |=> s_r.st == ST_SKIP &&
      s_r.sda_oe_n;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("bad addr acked");

  property p_addr_hit;
    @(posedge mclk_in) disable iff (!resetn_in)
    s_byte_done(ST_ADDR) and addr_hit |=> s_r.st == ST_ACK &&
      !s_r.sda_oe_n;
  endproperty
  a_addr_hit: assert property (p_addr_hit) else $error("addr not acked");

  property p_cmd_ack;
    @(posedge mclk_in) disable iff (!resetn_in)
    s_byte_done(ST_CMD) |=> (s_r.sda_oe_n == !is_mapped(s_r.ptr)) &&
      s_r.ptr_ok == is_mapped(s_r.ptr);
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("command ack wrong");

  property p_one_write;
    @(posedge mclk_in) disable iff (!resetn_in)
    s_byte_done(ST_WDATA) |=> !s_r.ptr_ok;
  endproperty
  a_one_write: assert property (p_one_write) else $error("pointer kept");

  property p_ctrl_write;
    @(posedge mclk_in) disable iff (!resetn_in)
    s_byte_done(ST_WDATA) and (s_r.ptr_ok && s_r.ptr == REG_CONTROL)
    |=> s_r.ctrl == $past(s_r.shreg[CTL_W-1:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl lost");

  property p_reset_dc;
    @(posedge mclk_in)
    !resetn_in |=> !s_r.ctrl[CTL_HALF_DUTY] || resetn_in;
  endproperty
  a_reset_dc: assert property (p_reset_dc) else $error("dc not cleared");
endmodule
`default_nettype wire

// [sim/tcx_host_model.sv]
/*
  Behavioural 2-wire bus master for the oscillator control block.
  Assumes SDA is resolved outside with a pull-up; moves on mclk falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tcx_host_model #(
  parameter int HALF = 16
) (
  input wire logic mclk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  // Data changes only while SCL is low, sampled mid high phase
  task automatic clk_bit(input logic b, output logic r);
    sda_out = b;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF / 2);
    r = sda_in;
    wt(HALF / 2);
    scl_out = 1'b0;
    wt(2);
  endtask
  task automatic start();
    sda_out = 1'b1;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF);
    sda_out = 1'b0;
    wt(HALF);
    scl_out = 1'b0;
    wt(2);
  endtask
  task automatic stop();
    sda_out = 1'b0;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF);
    sda_out = 1'b1;
    wt(HALF);
  endtask
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
    end
    clk_bit(1'b1, r);
    ack = (r === 1'b0);
  endtask
  task automatic byte_in(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(~mack, r);
  endtask
  // Command byte resent before every access
  task automatic wr(input logic [6:0] a, input logic [7:0] c,
                    input logic [7:0] d, output logic [2:0] k);
    start();
    byte_out({a, 1'b0}, k[2]);
    byte_out(c, k[1]);
    byte_out(d, k[0]);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c,
                    input logic two, output logic [15:0] d,
                    output logic ok);
    logic [2:0] k;
    start();
    byte_out({a, 1'b0}, k[2]);
    byte_out(c, k[1]);
    start();
    byte_out({a, 1'b1}, k[0]);
    byte_in(two, d[15:8]);
    d[7:0] = 8'h00;
    if (two) begin
      byte_in(1'b0, d[7:0]);
    end
    stop();
    ok = &k;
  endtask
endmodule
`default_nettype wire

// [sim/tb_tcx_ctrl_top.sv]
/*
  Self-checking bench of the oscillator control top.
  Assumes the host model drives the 2-wire pins; SDA has a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_tcx_ctrl_top;
  import tcx_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic address_select = 1'b0;
  logic temp_done = 1'b0;
  logic [9:0] temp_result = 10'h000;
  logic [9:0] factory_comp = 10'h100;
  logic scl, sda_m, sda_oe_n, sda_w, conv_start, base_clk, div_clk;
  logic [9:0] crystal_load;
  int fail_count = 0;
  int tests_run = 0;
  int conv_cnt = 0;
  int base_tog = 0;
  int div_tog = 0;
  assign sda_w = sda_m & sda_oe_n;
  initial begin
    forever #5 mclk = ~mclk;
  end
  tcx_ctrl_top u_dut (.mclk_in(mclk), .resetn_in(resetn), .ce_in(ce),
    .scl_in(scl), .sda_in(sda_w), .sda_out(), .sda_oe_n_out(sda_oe_n),
    .address_select_pin_in(address_select), .temp_done_in(temp_done),
    .temp_result_in(temp_result), .factory_comp_in(factory_comp),
    .conv_start_out(conv_start), .crystal_load_out(crystal_load),
    .base_clock_output_out(base_clk), .divided_clock_output_out(div_clk));
  tcx_host_model #(.HALF(16)) u_host (.mclk_in(mclk), .sda_in(sda_w),
    .scl_out(scl), .sda_out(sda_m));
  always @(posedge mclk) begin
    if (conv_start === 1'b1) begin
      conv_cnt++;
    end
  end
  always @(base_clk) base_tog++;
  always @(div_clk) div_tog++;
  task automatic give_verdict();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] c, input logic [7:0] d);
    logic [2:0] k;
    u_host.wr({6'h22, address_select}, c, d, k);
    check({13'h0000, k}, 16'h0007, "write acks");
  endtask
  task automatic rreg(input logic [7:0] c, input logic [7:0] e);
    logic [15:0] d;
    logic ok;
    u_host.rd({6'h22, address_select}, c, 1'b0, d, ok);
    check({7'h00, ok, d[15:8]}, {8'h01, e}, "read");
  endtask
  task automatic t_reset();
    check(conv_cnt[15:0], 16'h0001, "start after reset");
    rreg(REG_CONTROL, 8'h0c);
    rreg(REG_DIVIDER, 8'h00);
    rreg(REG_FREQ_OFFSET, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_regs();
    logic [2:0] k;
    wreg(REG_DIVIDER, 8'ha5);
    rreg(REG_DIVIDER, 8'ha5);
    wreg(REG_FREQ_OFFSET, 8'h7f);
    rreg(REG_FREQ_OFFSET, 8'h7f);
    wreg(REG_FREQ_OFFSET, 8'h80);
    rreg(REG_FREQ_OFFSET, 8'h80);
    wreg(REG_CONTROL, 8'hf5);
    rreg(REG_CONTROL, 8'h05);
    u_host.wr(7'h44, REG_TEMP_HI, 8'h12, k);
    check({13'h0000, k}, 16'h0006, "write to read-only");
    u_host.wr(7'h44, 8'h61, 8'h12, k);
    check({14'h0000, k[2:1]}, 16'h0002, "unmapped command");
    u_host.wr(7'h45, REG_DIVIDER, 8'h12, k);
    check({13'h0000, k}, 16'h0000, "wrong address");
    address_select = 1'b1;
    repeat (4) @(negedge mclk);
    u_host.wr(7'h44, REG_DIVIDER, 8'h12, k);
    check({13'h0000, k}, 16'h0000, "old address");
    wreg(REG_DIVIDER, 8'h3c);
    rreg(REG_DIVIDER, 8'h3c);
    $display("test registers done");
  endtask
  task automatic measure(output int per, output int hi);
    logic p;
    int g;
    per = 0;
    hi = 0;
    p = 1'b1;
    g = 0;
    while (!(p === 1'b0 && div_clk === 1'b1) && g < 600) begin
      p = div_clk;
      @(negedge mclk);
      g++;
    end
    do begin
      hi += (div_clk === 1'b1);
      per++;
      p = div_clk;
      @(negedge mclk);
    end while (!(p === 1'b0 && div_clk === 1'b1) && per < 600);
  endtask
  task automatic t_div();
    logic [7:0] nv [4] = '{8'h01, 8'h02, 8'h02, 8'hff};
    logic hv [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    int per, hi, n;
    for (int i = 0; i < 4; i++) begin
      n = nv[i] + 1;
      wreg(REG_DIVIDER, nv[i]);
      wreg(REG_CONTROL, {7'h06, hv[i]});
      measure(per, hi);
      check(per[15:0], hv[i] ? 16'(2 * n) : 16'(n), "period");
      if (hv[i]) begin
        check(hi[15:0], 16'(n), "high time");
      end else begin
        check(hi[15:0], 16'(n / 2), "short high time");
      end
    end
    $display("test divider done");
  endtask
  task automatic t_enable();
    logic [7:0] cv [4] = '{8'h04, 8'h08, 8'h00, 8'h0c};
    int b0, d0;
    wreg(REG_DIVIDER, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wreg(REG_CONTROL, cv[i]);
      repeat (8) @(negedge mclk);
      b0 = base_tog;
      d0 = div_tog;
      repeat (40) @(negedge mclk);
      check({15'h0000, base_tog != b0}, {15'h0000, cv[i][2]}, "base");
      check({15'h0000, div_tog != d0}, {15'h0000, cv[i][3]}, "div");
    end
    $display("test enables done");
  endtask
  task automatic conv(input logic [9:0] t);
    temp_result = t;
    temp_done = 1'b1;
    @(negedge mclk);
    temp_done = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic t_temp();
    logic [15:0] d;
    logic ok;
    int c0;
    wreg(REG_FREQ_OFFSET, 8'hfe);
    check({6'h00, crystal_load}, 16'h0000, "load before update");
    c0 = conv_cnt;
    conv(10'h3a6);
    check({6'h00, crystal_load}, 16'h00fe, "load after update");
    check(16'(conv_cnt - c0), 16'h0001, "next start");
    u_host.rd({6'h22, address_select}, REG_TEMP_HI, 1'b1, d, ok);
    check(d, 16'he980, "two byte read");
    rreg(REG_TEMP_LO, 8'h80);
    u_host.rd({6'h22, address_select}, REG_TEMP_HI, 1'b0, d, ok);
    check({7'h00, ok, d[15:8]}, 16'h01e9, "one byte read");
    check(16'(conv_cnt - c0), 16'h0001, "reads start nothing");
    conv(10'h155);
    u_host.rd({6'h22, address_select}, REG_TEMP_HI, 1'b1, d, ok);
    check(d, 16'h5540, "latest result");
    $display("test temperature done");
  endtask
  task automatic t_ce();
    int c0;
    c0 = conv_cnt;
    ce = 1'b0;
    conv(10'h0aa);
    ce = 1'b1;
    repeat (2) @(negedge mclk);
    check({6'h00, crystal_load}, 16'h00fe, "frozen load");
    check(16'(conv_cnt - c0), 16'h0000, "frozen start");
    rreg(REG_TEMP_HI, 8'h55);
    $display("test clock enable done");
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    repeat (16) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset();
    t_regs();
    t_div();
    t_enable();
    t_temp();
    t_ce();
    give_verdict();
  end
endmodule
`default_nettype wire
